// >>> rtl/drcd_pkg.sv
// shared constants and types for the read command decoder
package drcd_pkg;
    localparam logic [4:0] DRCD_OP_READ = 5'h06;
    localparam logic [4:0] DRCD_OP_READ2 = 5'h0C;
    localparam logic [5:0] DRCD_OP_TRACK = 6'h02;
    localparam int DRCD_FLAG_MT_POS = 7;
    localparam int DRCD_FLAG_MOD_POS = 6;
    localparam int DRCD_FLAG_SK_POS = 5;
    localparam int DRCD_HEAD_POS = 2;
    localparam logic [4:0] DRCD_UNIT_RSVD = 5'h00;
    localparam logic [3:0] DRCD_PARAM_COUNT = 4'h9;
    localparam logic [2:0] DRCD_RESULT_COUNT = 3'h7;
    localparam logic [2:0] DRCD_N_MAX = 3'h7;
    localparam logic [7:0] DRCD_ST0_INVALID = 8'h80;
    localparam logic [7:0] DRCD_BYTE_RESET = 8'h00;

    typedef enum logic [4:0] {
        DRCD_IDLE = 5'b00001,
        DRCD_PARAM = 5'b00010,
        DRCD_EXEC = 5'b00100,
        DRCD_NOTIFY = 5'b01000,
        DRCD_RESULT = 5'b10000
    } drcd_phase_t;

    typedef enum logic [1:0] {
        DRCD_KIND_READ = 2'h0,
        DRCD_KIND_READ2 = 2'h1,
        DRCD_KIND_TRACK = 2'h2
    } drcd_kind_t;

    // parameters handed to the execution engine
    typedef struct packed {
        drcd_kind_t kind;
        logic multitrack_flag;
        logic modulation_select;
        logic ignore_deleted_flag;
        logic head_pick;
        logic unit_pick_hi;
        logic unit_pick_lo;
        logic [8:0] cylinder;
        logic [7:0] head;
        logic [7:0] record;
        logic [7:0] size_code;
        logic [7:0] last_sector_num;
        logic [7:0] gap_size;
        logic [7:0] sector_byte_limit;
        logic [15:0] sector_bytes;
    } drcd_cmd_t;

    // outcome reported by the execution engine
    typedef struct packed {
        logic [7:0] result_state_a;
        logic [7:0] result_state_b;
        logic [7:0] result_state_c;
        logic [8:0] cylinder;
        logic [7:0] head;
        logic [7:0] record;
        logic [7:0] size_code;
    } drcd_res_t;

    typedef struct packed {
        logic queue_on;
        logic [3:0] queue_level;
        logic [7:0] precomp_first_cyl;
    } drcd_cfg_t;

    typedef struct packed {
        drcd_phase_t phase;
        logic [3:0] count;
        drcd_cmd_t cmd;
        drcd_res_t res;
        logic [7:0] rd_data;
        logic irq;
        logic exec_start;
        logic invalid;
        drcd_cfg_t cfg;
    } drcd_state_t;

    // bytes per sector from size code: 128 shifted left by the code, codes above 7 count as 7
    function automatic logic [15:0] drcd_sector_bytes(input logic [7:0] n);
        logic [2:0] c;
        c = (n[7:3] != 5'h00) ? DRCD_N_MAX : n[2:0];
        return 16'h0080 << c;
    endfunction
endpackage

// >>> rtl/drcd_decoder.sv
// command decoder and phase sequencer for the sector and track reads
`timescale 1ns/1ps
// What this block and the execution engine it drives do
// R1: normal read opcode is flags in bits 7..5 and 00110 in the low five bits.
// R2: second read opcode is the same flags with 01100 low bits, same parameters and results.
// R3: track read opcode has bit 7 clear, modulation in bit 6 and 000010 low bits.
// R4: track read walks every sector from index hole to the last sector number.
// R5: second byte has bits 7..3 zero, bit 2 head pick and bits 1..0 the unit.
// R6: host then writes cylinder, head, record, size, last sector, gap, data length.
// R7: result phase offers status a, b, c then cylinder, head, record and size.
// R8: skip flag passes deleted sectors, modulation picks encoding, multitrack spans heads.
// R9: size code sets bytes per sector for id matching and byte counting.
// R10: cylinder values from 0 to 511 are carried in full in exec_cmd; the result byte returns only bits 7..0.
// R11: with lock set, queue and precomp settings survive a software reset.
// R12: every valid command runs command, execution, result phases in order; an invalid one skips execution.
// R13: bytes move only when the ready and direction flags allow it.
// R14: end of execution raises the interrupt before the result phase.
module drcd_decoder
    import drcd_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic soft_reset,
    input wire logic lock_setting,
    input wire drcd_cfg_t cfg_in,
    input wire logic cfg_load,
    input wire logic host_wr,
    input wire logic host_rd,
    input wire logic [7:0] host_wdata,
    input wire logic cyl_msb,
    input wire logic exec_done,
    input wire drcd_res_t exec_result,
    output logic [7:0] host_rdata,
    output logic host_ready_flag,
    output logic transfer_direction_flag,
    output logic busy,
    output logic irq,
    output logic exec_start,
    output drcd_cmd_t exec_cmd,
    output logic track_from_index,
    output drcd_cfg_t cfg_out
);
    drcd_state_t s_reg;
    drcd_state_t s_next;
    logic wr_take;
    logic rd_take;
    logic [2:0] op_match;

    // opcode form match, one bit per read command; all clear for a byte naming none
    function automatic logic [2:0] drcd_opcode_match(input logic [7:0] op);
        logic [2:0] m;
        // R1: normal read, flags above
        m[0] = (op[4:0] == DRCD_OP_READ);
        // R2: second read, same flags
        m[1] = (op[4:0] == DRCD_OP_READ2);
        // R3: track read, modulation flag only, no mt or skip
        m[2] = !op[DRCD_FLAG_MT_POS] && (op[5:0] == DRCD_OP_TRACK);
        return m;
    endfunction

    // R7: result byte by position
    function automatic logic [7:0] drcd_result_byte(input drcd_res_t r, input logic [3:0] idx);
        logic [7:0] b;
        case (idx)
            4'h0: b = r.result_state_a;
            4'h1: b = r.result_state_b;
            4'h2: b = r.result_state_c;
            4'h3: b = r.cylinder[7:0];
            4'h4: b = r.head;
            4'h5: b = r.record;
            4'h6: b = r.size_code;
            default: b = DRCD_BYTE_RESET;
        endcase
        return b;
    endfunction

    // R13: strobes gated by flags
    // a stray strobe in the wrong direction must never move a byte
    assign wr_take = host_wr && host_ready_flag && !transfer_direction_flag;
    assign rd_take = host_rd && host_ready_flag && transfer_direction_flag;
    assign op_match = drcd_opcode_match(host_wdata);

    always_comb begin
        s_next = s_reg;
        s_next.exec_start = 1'b0;
        if (cfg_load) begin
            s_next.cfg = cfg_in;
        end
        // R11: lock keeps config
        if (soft_reset && !lock_setting) begin
            s_next.cfg = '0;
        end
        case (s_reg.phase)
            DRCD_IDLE: begin
                // R13: write only when ready
                if (wr_take && !soft_reset) begin
                    s_next.cmd = '0;
                    s_next.count = 4'h1;
                    s_next.invalid = 1'b0;
                    s_next.cmd.modulation_select = host_wdata[DRCD_FLAG_MOD_POS];
                    s_next.phase = DRCD_PARAM;
                    // R1: normal read opcode
                    if (op_match[0]) begin
                        s_next.cmd.kind = DRCD_KIND_READ;
                        s_next.cmd.multitrack_flag = host_wdata[DRCD_FLAG_MT_POS];
                        s_next.cmd.ignore_deleted_flag = host_wdata[DRCD_FLAG_SK_POS];
                    // R2: second read opcode
                    end else if (op_match[1]) begin
                        s_next.cmd.kind = DRCD_KIND_READ2;
                        s_next.cmd.multitrack_flag = host_wdata[DRCD_FLAG_MT_POS];
                        s_next.cmd.ignore_deleted_flag = host_wdata[DRCD_FLAG_SK_POS];
                    // R3: track read, no mt or skip
                    end else if (op_match[2]) begin
                        s_next.cmd.kind = DRCD_KIND_TRACK;
                    end else begin
                        // unknown opcode: straight to a one byte invalid result
                        s_next.phase = DRCD_RESULT;
                        s_next.count = 4'h0;
                        s_next.invalid = 1'b1;
                        s_next.rd_data = DRCD_ST0_INVALID;
                    end
                end
            end
            DRCD_PARAM: begin
                // R6: fixed parameter order
                if (wr_take) begin
                    s_next.count = s_reg.count + 4'h1;
                    case (s_reg.count)
                        4'h1: begin
                            // R5: unit byte layout, reserved bits flag a bad command
                            s_next.cmd.head_pick = host_wdata[DRCD_HEAD_POS];
                            s_next.cmd.unit_pick_hi = host_wdata[1];
                            s_next.cmd.unit_pick_lo = host_wdata[0];
                            if (host_wdata[7:3] != DRCD_UNIT_RSVD) begin
                                s_next.invalid = 1'b1;
                            end
                        end
                        // R10: ninth cylinder bit kept
                        4'h2: s_next.cmd.cylinder = {cyl_msb, host_wdata};
                        4'h3: s_next.cmd.head = host_wdata;
                        4'h4: s_next.cmd.record = host_wdata;
                        4'h5: begin
                            s_next.cmd.size_code = host_wdata;
                            // R9: size code to byte count
                            s_next.cmd.sector_bytes = drcd_sector_bytes(host_wdata);
                        end
                        4'h6: s_next.cmd.last_sector_num = host_wdata;
                        4'h7: s_next.cmd.gap_size = host_wdata;
                        default: s_next.cmd.sector_byte_limit = host_wdata;
                    endcase
                    if (s_reg.count == DRCD_PARAM_COUNT - 4'h1) begin
                        if (s_reg.invalid) begin
                            s_next.phase = DRCD_RESULT;
                            s_next.count = 4'h0;
                            s_next.rd_data = DRCD_ST0_INVALID;
                        end else begin
                            // R12: command then execution
                            s_next.phase = DRCD_EXEC;
                            s_next.exec_start = 1'b1;
                        end
                    end
                end
            end
            DRCD_EXEC: begin
                // R8: flags travel to the engine in exec_cmd
                if (exec_done) begin
                    s_next.res = exec_result;
                    s_next.phase = DRCD_NOTIFY;
                    // R14: interrupt at end of execution
                    s_next.irq = 1'b1;
                end
            end
            DRCD_NOTIFY: begin
                // one cycle of interrupt before the first result byte is offered
                s_next.phase = DRCD_RESULT;
                s_next.count = 4'h0;
                s_next.rd_data = drcd_result_byte(s_reg.res, 4'h0);
            end
            DRCD_RESULT: begin
                // R13: read only when direction is out
                if (rd_take) begin
                    s_next.irq = 1'b0;
                    s_next.count = s_reg.count + 4'h1;
                    // R7: result byte order
                    s_next.rd_data = drcd_result_byte(s_reg.res, s_reg.count + 4'h1);
                    if (s_reg.invalid || s_reg.count == {1'b0, DRCD_RESULT_COUNT} - 4'h1) begin
                        s_next.phase = DRCD_IDLE;
                        s_next.rd_data = DRCD_BYTE_RESET;
                    end
                end
            end
            default: s_next.phase = DRCD_IDLE;
        endcase
        // software reset aborts any command but spares locked settings
        if (soft_reset) begin
            s_next.phase = DRCD_IDLE;
            s_next.irq = 1'b0;
            s_next.exec_start = 1'b0;
            s_next.rd_data = DRCD_BYTE_RESET;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            s_reg <= '{phase: DRCD_IDLE, default: '0};
        end else begin
            s_reg <= s_next;
        end
    end

    // R13: ready and direction flags
    assign host_ready_flag = (s_reg.phase == DRCD_IDLE) || (s_reg.phase == DRCD_PARAM)
        || (s_reg.phase == DRCD_RESULT);
    assign transfer_direction_flag = (s_reg.phase == DRCD_RESULT);
    assign busy = (s_reg.phase != DRCD_IDLE);
    assign host_rdata = s_reg.rd_data;
    assign irq = s_reg.irq;
    assign exec_start = s_reg.exec_start;
    assign exec_cmd = s_reg.cmd;
    // R4: track read starts at index hole
    assign track_from_index = (s_reg.cmd.kind == DRCD_KIND_TRACK);
    assign cfg_out = s_reg.cfg;
endmodule

// >>> test/drcd_properties.sv
// port assertions for the read command decoder
`timescale 1ns/1ps
module drcd_properties
    import drcd_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic soft_reset,
    input wire logic lock_setting,
    input wire logic cfg_load,
    input wire logic exec_done,
    input wire drcd_res_t exec_result,
    input wire logic [7:0] host_rdata,
    input wire logic host_ready_flag,
    input wire logic transfer_direction_flag,
    input wire logic busy,
    input wire logic irq,
    input wire logic exec_start,
    input wire drcd_cmd_t exec_cmd,
    input wire logic track_from_index,
    input wire drcd_cfg_t cfg_out
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    logic in_exec;
    logic [7:0] st_a;
    assign in_exec = busy && !host_ready_flag && !irq;
    assign st_a = exec_result.result_state_a;
    chk_idle_ready: assert property (!busy |-> host_ready_flag && !transfer_direction_flag)
        else $error("idle without write permission");
    chk_dir_ready: assert property (transfer_direction_flag |-> host_ready_flag && busy)
        else $error("read direction without ready");
    chk_notify_seq: assert property (disable iff (reset || soft_reset)
        in_exec && exec_done |=> irq && !host_ready_flag ##1 transfer_direction_flag)
        else $error("no notify step before result");
    chk_first_status: assert property (disable iff (reset || soft_reset)
        in_exec && exec_done |=> ##1 host_rdata == $past(st_a, 2))
        else $error("first result byte wrong");
    chk_rdata_quiet: assert property (!transfer_direction_flag |-> host_rdata == 8'h00)
        else $error("result byte outside result phase");
    chk_start_pulse: assert property (exec_start |=> !exec_start)
        else $error("start longer than one cycle");
    chk_start_exec: assert property (exec_start |-> busy && !host_ready_flag)
        else $error("start outside execution");
    chk_sector_bytes: assert property (exec_start |-> exec_cmd.sector_bytes ==
        (16'h0080 << ((|exec_cmd.size_code[7:3]) ? 3'h7 : exec_cmd.size_code[2:0])))
        else $error("sector byte count wrong");
    chk_track_kind: assert property (exec_start |->
        track_from_index == (exec_cmd.kind == DRCD_KIND_TRACK))
        else $error("track flag disagrees with kind");
    chk_track_flags: assert property (exec_start && track_from_index |->
        !exec_cmd.multitrack_flag && !exec_cmd.ignore_deleted_flag)
        else $error("track read carries multitrack or skip");
    chk_cfg_lock: assert property (soft_reset && lock_setting && !cfg_load |=> $stable(cfg_out))
        else $error("locked settings lost");
    chk_cfg_clear: assert property (soft_reset && !lock_setting |=> cfg_out == '0)
        else $error("unlocked settings kept");
    cov_start: cover property (exec_start);
    cov_notify: cover property (in_exec && exec_done ##2 transfer_direction_flag);
    cov_lock: cover property (soft_reset && lock_setting);
endmodule

bind drcd_decoder drcd_properties u_props (.ref_clk(ref_clk), .reset(reset),
    .soft_reset(soft_reset), .lock_setting(lock_setting), .cfg_load(cfg_load),
    .exec_done(exec_done), .exec_result(exec_result), .host_rdata(host_rdata),
    .host_ready_flag(host_ready_flag), .transfer_direction_flag(transfer_direction_flag),
    .busy(busy), .irq(irq), .exec_start(exec_start), .exec_cmd(exec_cmd),
    .track_from_index(track_from_index), .cfg_out(cfg_out));

// >>> test/drcd_host_model.sv
// host side model that writes command bytes and reads result bytes
`timescale 1ns/1ps
module drcd_host_model (
    input wire logic ref_clk,
    input wire logic host_ready_flag,
    input wire logic transfer_direction_flag,
    input wire logic [7:0] host_rdata,
    output logic host_wr,
    output logic host_rd,
    output logic [7:0] host_wdata
);
    initial begin
        host_wr = 1'b0;
        host_rd = 1'b0;
        host_wdata = 8'h00;
    end
    task automatic send(input logic [7:0] b);
        // an idle edge first, so a strobe just lowered is never raised in the same step
        @(negedge ref_clk);
        while (!(host_ready_flag === 1'b1 && transfer_direction_flag === 1'b0)) begin
            @(negedge ref_clk);
        end
        host_wr = 1'b1;
        host_wdata = b;
        @(negedge ref_clk);
        host_wr = 1'b0;
        // released bus shows the inverse so stale bytes never look valid
        host_wdata = ~b;
    endtask
    task automatic read(output logic [7:0] b);
        @(negedge ref_clk);
        while (!(host_ready_flag === 1'b1 && transfer_direction_flag === 1'b1)) begin
            @(negedge ref_clk);
        end
        b = host_rdata;
        host_rd = 1'b1;
        @(negedge ref_clk);
        host_rd = 1'b0;
    endtask
endmodule

// >>> test/tb.sv
// self-checking bench for the read command decoder
`timescale 1ns/1ps
module tb;
    import drcd_pkg::*;
    logic ref_clk = 1'b0, reset = 1'b1, soft_reset = 1'b0, lock_setting = 1'b0;
    logic cfg_load = 1'b0, cyl_msb = 1'b0, exec_done = 1'b0;
    drcd_cfg_t cfg_in = '0;
    drcd_res_t exec_result = '0;
    logic host_wr, host_rd, host_ready_flag, transfer_direction_flag, busy, irq;
    logic exec_start, track_from_index;
    logic [7:0] host_wdata, host_rdata;
    drcd_cmd_t exec_cmd;
    drcd_cfg_t cfg_out;
    int err_total = 0;
    int checked = 0;
    logic [7:0] ops [8] = '{8'h46, 8'hE6, 8'h0C, 8'hAC, 8'h02, 8'h42, 8'h82, 8'h07};
    logic [1:0] kinds [8] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h0, 2'h0};
    logic oks [8] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
    always #4 ref_clk = ~ref_clk;
    drcd_decoder uut (.ref_clk(ref_clk), .reset(reset), .soft_reset(soft_reset),
        .lock_setting(lock_setting), .cfg_in(cfg_in), .cfg_load(cfg_load), .host_wr(host_wr),
        .host_rd(host_rd), .host_wdata(host_wdata), .cyl_msb(cyl_msb), .exec_done(exec_done),
        .exec_result(exec_result), .host_rdata(host_rdata), .host_ready_flag(host_ready_flag),
        .transfer_direction_flag(transfer_direction_flag), .busy(busy), .irq(irq),
        .exec_start(exec_start), .exec_cmd(exec_cmd), .track_from_index(track_from_index),
        .cfg_out(cfg_out));
    drcd_host_model u_host (.ref_clk(ref_clk), .host_ready_flag(host_ready_flag),
        .transfer_direction_flag(transfer_direction_flag), .host_rdata(host_rdata),
        .host_wr(host_wr), .host_rd(host_rd), .host_wdata(host_wdata));
    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("checked=%0d err_total=%0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic run_cmd(input logic [7:0] op, input logic [7:0] unit, input logic [8:0] cyl,
        input logic [1:0] kind, input logic ok);
        logic [7:0] p [8];
        logic [7:0] b;
        logic [55:0] r;
        logic good;
        int n;
        p = '{unit, cyl[7:0], 8'h01, 8'h03, 8'h02, 8'h12, 8'h1B, 8'hFF};
        good = ok && (unit[7:3] == 5'h00);
        r = good ? {8'h11, 8'h22, 8'h33, cyl[7:0], 8'h55, 8'h66, 8'h02} : {8'h80, 48'h0};
        u_host.send(op);
        cyl_msb = cyl[8];
        for (int k = 0; k < 8 && ok; k++) u_host.send(p[k]);
        if (good) begin
            n = 0;
            while (exec_start !== 1'b1 && n < 20) begin
                @(negedge ref_clk);
                n++;
            end
            check(exec_start, 1'b1);
            check(exec_cmd, drcd_cmd_t'{drcd_kind_t'(kind), op[7], op[6], op[5], unit[2],
                unit[1], unit[0], cyl, 8'h01, 8'h03, 8'h02, 8'h12, 8'h1B, 8'hFF, 16'h0200});
            check(track_from_index, kind == 2'h2);
            exec_result = '{8'h11, 8'h22, 8'h33, cyl, 8'h55, 8'h66, 8'h02};
            exec_done = 1'b1;
            @(negedge ref_clk);
            exec_done = 1'b0;
            check(irq, 1'b1);
        end
        for (int k = 0; k < (good ? 7 : 1); k++) begin
            u_host.read(b);
            check(b, r[55 - 8 * k -: 8]);
        end
        check({busy, irq}, 2'b00);
    endtask
    initial begin
        repeat (12) @(negedge ref_clk);
        reset = 1'b0;
        check({host_ready_flag, transfer_direction_flag, busy, irq}, 4'b1000);
        // rows cover every opcode form; the first sets the ninth cylinder bit
        for (int i = 0; i < 8; i++) run_cmd(ops[i], 8'h05, i == 0 ? 9'h100 : 9'(i), kinds[i], oks[i]);
        run_cmd(8'h46, 8'h0D, 9'h007, 2'h0, 1'b1);
        cfg_in = '{1'b1, 4'h5, 8'h20};
        cfg_load = 1'b1;
        @(negedge ref_clk);
        cfg_load = 1'b0;
        lock_setting = 1'b1;
        soft_reset = 1'b1;
        @(negedge ref_clk);
        check(cfg_out, cfg_in);
        // same reset held one more edge with the lock dropped
        lock_setting = 1'b0;
        @(negedge ref_clk);
        soft_reset = 1'b0;
        check(cfg_out, 13'h0000);
        // a reset in mid-command returns to idle and the next command runs whole
        u_host.send(8'h46);
        soft_reset = 1'b1;
        @(negedge ref_clk);
        soft_reset = 1'b0;
        check({busy, irq, host_ready_flag}, 3'b001);
        run_cmd(8'h42, 8'h02, 9'h0FF, 2'h2, 1'b1);
        stop_test();
    end
    initial begin
        #100000;
        err_total++;
        stop_test();
    end
endmodule
